// File: hdl/root_port_pm_event_config.sv
/*
 * Root port power state, wake status, port configuration, management and
 * control interrupt routing, receive checks and virtual channel registers.
 * Assumes configuration accesses from the port's own request logic on the
 * same clock, and slot and root status flags from neighbouring logic.
 */
`timescale 1ns/1ps

module root_port_pm_event_config (
    // Clock and resets
    input  wire logic                        i_clock,
    input  wire logic                        i_resetn,
    input  wire logic                        i_resume_resetn,
    // Configuration access
    input  wire logic                        i_cfg_valid,
    input  wire logic                        i_cfg_write,
    input  wire logic [11:0]                 i_cfg_addr,
    input  wire logic [3:0]                  i_cfg_byte_en,
    input  wire logic [31:0]                 i_cfg_wdata,
    output logic                             o_cfg_done,
    output logic      [31:0]                 o_cfg_rdata,
    // Wake and slot events
    input  wire logic                        i_wake_message,
    input  wire logic                        i_root_wake_status,
    input  wire logic                        i_link_active,
    input  wire logic                        i_link_active_changed_clear,
    input  wire logic                        i_command_completed,
    input  wire logic                        i_attention_pressed,
    input  wire logic                        i_presence_changed,
    output logic                             o_link_active_changed,
    output logic                             o_acpi_control_interrupt,
    output logic                             o_system_mgmt_interrupt,
    // Straps and port setup
    input  wire logic                        i_lane_reversal_strap,
    input  wire logic                        i_bridge_type_select,
    input  wire logic                        i_link_special_mode,
    input  wire logic [2:0]                  i_port_number,
    input  wire logic                        i_loopback_mode,
    output logic      [7:0]                  o_sub_class,
    output logic                             o_header_type_1,
    output logic      [2:0]                  o_unique_clock_exit_latency,
    output logic      [2:0]                  o_common_clock_exit_latency,
    output logic      [6:0]                  o_class_to_channel_map,
    // Power state effects
    output logic                             o_refuse_io_mem,
    output logic                             o_refuse_type1_cfg,
    output logic                             o_wake_enable_flag,
    // Receive checks
    input  wire logic                        i_rx_valid,
    input  wire root_port_pm_pkg::rx_kind_t  i_rx_kind,
    input  wire logic [7:0]                  i_rx_bus,
    input  wire logic [31:0]                 i_rx_addr,
    input  wire logic                        i_rx_in_window,
    input  wire logic                        i_bus_master_enable,
    input  wire logic [7:0]                  i_secondary_bus_num,
    input  wire logic [7:0]                  i_subordinate_bus_num,
    output logic                             o_rx_ready,
    output logic                             o_rx_unsupported,
    output logic                             o_rx_malformed_fatal,
    output logic                             o_rx_ioapic_forward,
    output logic                             o_loopback_xlation_active
);
    import root_port_pm_pkg::*;

    // ********************
    // State
    // ********************
    typedef struct packed {
        power_state_t power_state;
        logic         wake_received;
        logic [31:0]  misc;
        logic [31:0]  status;
        logic [2:0]   arb_select;
        logic [2:0]   port_arb_select;
        logic [6:0]   class_map;
        logic [1:0]   strap_sync;
        logic         link_active_q;
        logic         link_active_changed;
        logic [3:0]   slot_q;
        logic         root_wake_q;
        logic [31:0]  rdata;
        logic         done;
        logic         acpi_irq;
        logic         smi_irq;
        logic         refuse_io_mem;
        logic         bridge_type;
        logic         rx_ready;
        logic         rx_unsupported;
        logic         rx_malformed;
        logic         rx_ioapic;
        logic         xlation_active;
    } state_t;

    state_t state;
    state_t next_state;
    logic   wake_enable;
    logic   next_wake_enable;

    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] byte_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction : byte_mask

    // ********************
    // Next state
    // ********************
    logic [31:0] read_view;
    logic [31:0] merged;
    logic [11:0] dword_addr;
    logic        wr;
    logic [3:0]  slot_now;
    logic [3:0]  slot_rise;
    logic        pm_event;
    logic        hp_event;
    logic [31:0] status_set;
    logic [31:0] status_clear;
    logic        is_mem;
    logic        bus_bad;
    logic        range_bad;
    logic        master_bad;
    logic        malformed;
    logic [16:0] window_index;

    always_comb begin
        next_state       = state;
        next_wake_enable = wake_enable;
        dword_addr       = i_cfg_addr & DWORD_ALIGN_MASK;
        wr               = i_cfg_valid & i_cfg_write;

        // Lane reversal strap synchroniser
        next_state.strap_sync = {state.strap_sync[0], i_lane_reversal_strap};
        next_state.bridge_type = i_bridge_type_select;

        // Current dword view for reads and byte-enable merge
        read_view = '0;
        unique case (dword_addr)
            OFF_PM_CONTROL_STATUS: begin
                read_view[1:0]                  = state.power_state;
                read_view[PM_WAKE_ENABLE_BIT]   = wake_enable;
                read_view[PM_WAKE_RECEIVED_BIT] = state.wake_received;
            end
            OFF_MISC_PORT_CONFIG: begin
                read_view                        = state.misc & MISC_RW_MASK;
                read_view[MISC_LANE_REVERSE_BIT] = state.strap_sync[1];
                read_view[MISC_BRIDGE_TYPE_BIT]  = state.bridge_type;
            end
            OFF_SMI_SCI_STATUS: begin
                read_view = state.status;
            end
            OFF_LINK_MODE_STATUS & DWORD_ALIGN_MASK: begin
                read_view[31:16]                   = LINK_MODE_RESET;
                read_view[16 + LINK_MODE_FLAG_BIT] = i_link_special_mode;
            end
            OFF_VC_CAP_HEADER: begin
                read_view = VC_CAP_HEADER_RESET;
            end
            OFF_VC_CAP_SECOND: begin
                read_view = VC_CAP_SECOND_RESET;
            end
            OFF_PORT_VC_CONTROL: begin
                // Load bit reads 0, status half reads 0
                read_view[ARB_SELECT_LSB +: 3] = state.arb_select;
            end
            OFF_VC0_RES_CAP: begin
                read_view = VC0_RES_CAP_RESET;
            end
            OFF_VC0_RES_CONTROL: begin
                // Enable bit and class 0 stay set
                read_view = VC0_RES_CONTROL_RESET & ~VC0_CTL_RW_MASK;
                read_view[PORT_ARB_SELECT_LSB +: 3] = state.port_arb_select;
                read_view[CLASS_MAP_LSB +: 7]       = state.class_map;
            end
            default: begin
                read_view = '0;
            end
        endcase
        merged = (read_view & ~byte_mask(i_cfg_byte_en)) | (i_cfg_wdata & byte_mask(i_cfg_byte_en));

        next_state.done  = i_cfg_valid;
        next_state.rdata = (i_cfg_valid && !i_cfg_write) ? read_view : '0;

        // Register writes
        if (wr) begin
            unique case (dword_addr)
                OFF_PM_CONTROL_STATUS: begin
                    if (merged[1:0] == PS_FULL_ON || merged[1:0] == PS_HOT_LOW) begin
                        next_state.power_state = power_state_t'(merged[1:0]);
                    end
                    next_wake_enable = merged[PM_WAKE_ENABLE_BIT];
                end
                OFF_MISC_PORT_CONFIG: begin
                    next_state.misc = merged & MISC_RW_MASK;
                end
                OFF_PORT_VC_CONTROL: begin
                    next_state.arb_select = merged[ARB_SELECT_LSB +: 3];
                end
                OFF_VC0_RES_CONTROL: begin
                    next_state.port_arb_select = merged[PORT_ARB_SELECT_LSB +: 3];
                    next_state.class_map       = merged[CLASS_MAP_LSB +: 7];
                end
                default: begin
                end
            endcase
        end

        // Link active change flag, set wins over clear
        next_state.link_active_q = i_link_active;
        if (i_link_active_changed_clear) begin
            next_state.link_active_changed = 1'b0;
        end
        if (i_link_active != state.link_active_q) begin
            next_state.link_active_changed = 1'b1;
        end

        // Wake received: set by message, dropped when root wake status is cleared
        next_state.root_wake_q = i_root_wake_status;
        if (state.root_wake_q && !i_root_wake_status) begin
            next_state.wake_received = 1'b0;
        end
        if (i_wake_message) begin
            next_state.wake_received = 1'b1;
        end

        // Event edges: link active changed, command done, button, presence
        slot_now = {state.link_active_changed, i_command_completed, i_attention_pressed, i_presence_changed};
        next_state.slot_q = slot_now;
        slot_rise = slot_now & ~state.slot_q;
        pm_event  = i_root_wake_status & ~state.root_wake_q;
        hp_event  = |slot_rise;

        status_set = '0;
        status_set[STS_PM_CTRL_BIT] = pm_event & state.misc[MISC_PM_CTRL_IRQ_BIT];
        status_set[STS_HP_CTRL_BIT] = hp_event & state.misc[MISC_HP_CTRL_IRQ_BIT];
        status_set[STS_LINK_ACTIVE_BIT -: 4] = slot_rise & {4{state.misc[MISC_HP_MGMT_IRQ_BIT]}};
        status_set[STS_PM_MGMT_BIT] = pm_event & state.misc[MISC_PM_MGMT_IRQ_BIT];

        status_clear = (wr && dword_addr == OFF_SMI_SCI_STATUS) ? merged & byte_mask(i_cfg_byte_en) : '0;
        next_state.status = (state.status & ~status_clear) | status_set;

        next_state.acpi_irq = next_state.status[STS_PM_CTRL_BIT] | next_state.status[STS_HP_CTRL_BIT];
        next_state.smi_irq  = |next_state.status[STS_LINK_ACTIVE_BIT:STS_PM_MGMT_BIT];

        next_state.refuse_io_mem = (next_state.power_state == PS_HOT_LOW);

        // Receive checks on memory requests only
        next_state.rx_ready = ~next_state.misc[MISC_HOLD_OFF_BIT];
        is_mem     = i_rx_valid & state.rx_ready & (i_rx_kind != RX_OTHER);
        bus_bad    = state.misc[MISC_BUS_CHECK_BIT]
                     & ((i_rx_bus < i_secondary_bus_num) | (i_rx_bus > i_subordinate_bus_num));
        range_bad  = state.misc[MISC_RANGE_CHECK_BIT] & ~i_rx_in_window;
        master_bad = state.misc[MISC_MASTER_CHECK_BIT] & ~i_bus_master_enable;
        malformed  = is_mem & (i_rx_kind == RX_MEM_READ) & bus_bad;
        next_state.rx_malformed   = malformed;
        next_state.rx_unsupported = is_mem & ~malformed
                                    & (((i_rx_kind == RX_MEM_WRITE) & bus_bad) | range_bad | master_bad);

        window_index = IOAPIC_WINDOW_BASE[31:IOAPIC_WINDOW_BITS] + {14'h0000, i_port_number} - IOAPIC_PORT_STEP;
        next_state.rx_ioapic = is_mem & state.misc[MISC_IOAPIC_BIT]
                               & (i_rx_addr[31:IOAPIC_WINDOW_BITS] == window_index);

        next_state.xlation_active = next_state.misc[MISC_XLATION_BIT] & i_loopback_mode;
    end

    // ********************
    // Registers
    // ********************
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state           <= '0;
            state.misc      <= MISC_PORT_CONFIG_RESET & MISC_RW_MASK;
            state.class_map <= VC0_RES_CONTROL_RESET[CLASS_MAP_LSB +: 7];
            state.rx_ready  <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // Resume-well storage survives warm reset
    always_ff @(posedge i_clock or negedge i_resume_resetn) begin
        if (!i_resume_resetn) begin
            wake_enable <= 1'b0;
        end else begin
            wake_enable <= next_wake_enable;
        end
    end

    // ********************
    // Outputs
    // ********************
    assign o_cfg_done                  = state.done;
    assign o_cfg_rdata                 = state.rdata;
    assign o_link_active_changed       = state.link_active_changed;
    assign o_acpi_control_interrupt    = state.acpi_irq;
    assign o_system_mgmt_interrupt     = state.smi_irq;
    assign o_sub_class                 = state.bridge_type ? SUB_CLASS_HOST : SUB_CLASS_P2P;
    assign o_header_type_1             = ~state.bridge_type;
    assign o_unique_clock_exit_latency = state.misc[MISC_UNIQUE_CLOCK_EXIT_LATENCY_LSB +: 3];
    assign o_common_clock_exit_latency = state.misc[MISC_COMMON_CLOCK_EXIT_LATENCY_LSB +: 3];
    assign o_class_to_channel_map      = state.class_map;
    assign o_refuse_io_mem             = state.refuse_io_mem;
    assign o_refuse_type1_cfg          = state.refuse_io_mem;
    assign o_wake_enable_flag          = wake_enable;
    assign o_rx_ready                  = state.rx_ready;
    assign o_rx_unsupported            = state.rx_unsupported;
    assign o_rx_malformed_fatal        = state.rx_malformed;
    assign o_rx_ioapic_forward         = state.rx_ioapic;
    assign o_loopback_xlation_active   = state.xlation_active;

endmodule : root_port_pm_event_config

// File: hdl/root_port_pm_pkg.sv
/*
 * Constants for the root port power, wake and event routing register block:
 * register offsets, reset values, field positions, masks and enumerations.
 * Assumes byte-addressed configuration space, accessed one dword at a time.
 */
package root_port_pm_pkg;

    // ********************
    // Register offsets (byte addresses in configuration space)
    // ********************
    localparam logic [11:0] OFF_PM_CONTROL_STATUS  = 12'h0A4;
    localparam logic [11:0] OFF_MISC_PORT_CONFIG   = 12'h0D8;
    localparam logic [11:0] OFF_SMI_SCI_STATUS     = 12'h0DC;
    localparam logic [11:0] OFF_LINK_MODE_STATUS   = 12'h0E2;
    localparam logic [11:0] OFF_VC_CAP_HEADER      = 12'h100;
    localparam logic [11:0] OFF_VC_CAP_SECOND      = 12'h108;
    localparam logic [11:0] OFF_PORT_VC_CONTROL    = 12'h10C;
    localparam logic [11:0] OFF_PORT_VC_STATUS     = 12'h10E;
    localparam logic [11:0] OFF_VC0_RES_CAP        = 12'h110;
    localparam logic [11:0] OFF_VC0_RES_CONTROL    = 12'h114;
    localparam logic [11:0] DWORD_ALIGN_MASK       = 12'hFFC;

    // ********************
    // Reset values
    // ********************
    localparam logic [31:0] MISC_PORT_CONFIG_RESET = 32'h0811_0000;
    localparam logic [15:0] LINK_MODE_RESET        = 16'h0007;
    localparam logic [31:0] VC_CAP_HEADER_RESET    = 32'h1801_0002;
    localparam logic [31:0] VC_CAP_SECOND_RESET    = 32'h0000_0001;
    localparam logic [31:0] VC0_RES_CAP_RESET      = 32'h0000_0001;
    localparam logic [31:0] VC0_RES_CONTROL_RESET  = 32'h8000_00FF;

    // ********************
    // Field positions
    // ********************
    localparam int PM_WAKE_RECEIVED_BIT   = 15;
    localparam int PM_WAKE_ENABLE_BIT     = 8;
    localparam int MISC_PM_CTRL_IRQ_BIT   = 31;
    localparam int MISC_HP_CTRL_IRQ_BIT   = 30;
    localparam int MISC_HOLD_OFF_BIT      = 29;
    localparam int MISC_XLATION_BIT       = 28;
    localparam int MISC_LANE_REVERSE_BIT  = 27;
    localparam int MISC_BUS_CHECK_BIT     = 26;
    localparam int MISC_RANGE_CHECK_BIT   = 25;
    localparam int MISC_MASTER_CHECK_BIT  = 24;
    localparam int MISC_UNIQUE_CLOCK_EXIT_LATENCY_LSB          = 18;
    localparam int MISC_COMMON_CLOCK_EXIT_LATENCY_LSB          = 15;
    localparam int MISC_IOAPIC_BIT        = 7;
    localparam int MISC_BRIDGE_TYPE_BIT   = 2;
    localparam int MISC_HP_MGMT_IRQ_BIT   = 1;
    localparam int MISC_PM_MGMT_IRQ_BIT   = 0;
    localparam logic [31:0] MISC_RW_MASK  = 32'hF71F_8083;
    localparam int STS_PM_CTRL_BIT        = 31;
    localparam int STS_HP_CTRL_BIT        = 30;
    localparam int STS_LINK_ACTIVE_BIT    = 4;
    localparam int STS_PM_MGMT_BIT        = 0;
    localparam int LINK_MODE_FLAG_BIT     = 15;
    localparam int ARB_SELECT_LSB         = 1;
    localparam int PORT_ARB_SELECT_LSB    = 17;
    localparam int CLASS_MAP_LSB          = 1;
    localparam logic [31:0] VC0_CTL_RW_MASK = 32'h000E_00FE;

    // ********************
    // Identity codes and address windows
    // ********************
    localparam logic [7:0]  SUB_CLASS_P2P        = 8'h04;
    localparam logic [7:0]  SUB_CLASS_HOST       = 8'h00;
    localparam logic [31:0] IOAPIC_WINDOW_BASE   = 32'hFEC1_0000;
    localparam int          IOAPIC_WINDOW_BITS   = 15;
    localparam logic [16:0] IOAPIC_PORT_STEP     = 17'h00001;

    // ********************
    // Enumerations
    // ********************
    typedef enum logic [1:0] {
        PS_FULL_ON = 2'b00,
        PS_HOT_LOW = 2'b11
    } power_state_t;

    typedef enum logic [1:0] {
        RX_MEM_WRITE = 2'b00,
        RX_MEM_READ  = 2'b01,
        RX_OTHER     = 2'b10
    } rx_kind_t;

endpackage : root_port_pm_pkg

// File: verif/link_partner_model.sv
/* Downstream device model: wake messages and link up or down.
   Assumes requests arrive just after a clock edge. */
`timescale 1ns/1ps
module link_partner_model (
    input  wire logic i_clock,
    input  wire logic i_send_wake,
    input  wire logic i_link_up,
    output logic      o_wake_message,
    output logic      o_link_active
);
    always @(posedge i_clock) begin
        o_wake_message <= i_send_wake;
        o_link_active  <= i_link_up;
    end
endmodule : link_partner_model

// File: verif/root_port_pm_chk.sv
/* Checker for the root port power and event block.
   Assumes binding to the top module; sees its ports only. */
`timescale 1ns/1ps
module root_port_pm_chk (
    input wire logic                       i_clock, i_resetn, i_cfg_valid, i_cfg_write, o_cfg_done,
    input wire logic [31:0]                o_cfg_rdata,
    input wire logic                       i_link_active, i_link_active_changed_clear, o_link_active_changed,
    input wire logic                       o_system_mgmt_interrupt, o_header_type_1, o_refuse_io_mem,
    input wire logic                       o_refuse_type1_cfg, i_rx_valid, o_rx_ready, o_rx_unsupported,
    input wire logic                       o_rx_malformed_fatal, i_loopback_mode, o_loopback_xlation_active,
    input wire logic [7:0]                 o_sub_class,
    input wire root_port_pm_pkg::rx_kind_t i_rx_kind
);
    import root_port_pm_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    a_done_follows: assert property (i_cfg_valid |=> o_cfg_done) else $error("done missing");
    a_rdata_idle: assert property (!o_cfg_done |-> o_cfg_rdata == 32'h0) else $error("rdata outside done");
    a_refuse_pair: assert property (o_refuse_io_mem == o_refuse_type1_cfg) else $error("refusals differ");
    a_refuse_cause: assert property (
        $changed(o_refuse_io_mem) |-> $past(i_cfg_valid & i_cfg_write) || $past(i_cfg_valid & i_cfg_write, 2))
        else $error("state moved unasked");
    a_link_change_set: assert property (
        $past(i_resetn) && $changed(i_link_active) |=> o_link_active_changed) else $error("link change lost");
    a_link_change_hold: assert property (
        o_link_active_changed && !i_link_active_changed_clear |=> o_link_active_changed) else $error("flag dropped");
    a_mgmt_irq_hold: assert property (
        o_system_mgmt_interrupt && !(i_cfg_valid && i_cfg_write) |=> o_system_mgmt_interrupt)
        else $error("irq dropped");
    a_sub_class_map: assert property (
        o_sub_class == (o_header_type_1 ? 8'h04 : 8'h00)) else $error("identity mismatch");
    a_rx_exclusive: assert property (!(o_rx_unsupported && o_rx_malformed_fatal)) else $error("both errors");
    a_rx_other_free: assert property (
        i_rx_valid && i_rx_kind == RX_OTHER |=> !o_rx_unsupported && !o_rx_malformed_fatal)
        else $error("exempt packet flagged");
    a_hold_off_quiet: assert property (
        !o_rx_ready |=> !o_rx_unsupported && !o_rx_malformed_fatal) else $error("hold-off broken");
    a_xlation_loop: assert property (
        o_loopback_xlation_active |-> $past(i_loopback_mode)) else $error("stray translation");
endmodule : root_port_pm_chk
bind root_port_pm_event_config root_port_pm_chk u_chk (.*);

// File: verif/tb_root_port_pm_event_config.sv
/* Self-checking bench for the root port power and event block.
   Assumes the partner model and the bound checker. */
`timescale 1ns/1ps
module tb_root_port_pm_event_config;
    import root_port_pm_pkg::*;
    logic i_clock = 0, i_resetn = 0, i_resume_resetn = 0, i_cfg_valid = 0, i_cfg_write = 0, send_wake = 0;
    logic [11:0] i_cfg_addr = '0;
    logic [3:0] i_cfg_byte_en = '0;
    logic [31:0] i_cfg_wdata = '0, i_rx_addr = '0, rd, o_cfg_rdata;
    logic i_wake_message, i_root_wake_status = 0, i_link_active, i_link_active_changed_clear = 0, link_up = 0;
    logic i_command_completed = 0, i_attention_pressed = 0, i_presence_changed = 0, i_loopback_mode = 0;
    logic i_lane_reversal_strap = 1, i_bridge_type_select = 0, i_link_special_mode = 1, i_rx_valid = 0;
    logic i_rx_in_window = 0, i_bus_master_enable = 0, o_cfg_done, o_link_active_changed, o_rx_ready;
    logic o_acpi_control_interrupt, o_system_mgmt_interrupt, o_header_type_1, o_refuse_io_mem;
    logic o_refuse_type1_cfg, o_wake_enable_flag, o_rx_unsupported, o_rx_malformed_fatal;
    logic o_rx_ioapic_forward, o_loopback_xlation_active;
    logic [2:0] i_port_number = 3'h2, o_unique_clock_exit_latency, o_common_clock_exit_latency;
    logic [7:0] i_rx_bus = '0, i_secondary_bus_num = 8'h02, i_subordinate_bus_num = 8'h05, o_sub_class;
    logic [6:0] o_class_to_channel_map;
    rx_kind_t i_rx_kind = RX_OTHER;
    int n_mismatch = 0, num_checks = 0;
    root_port_pm_event_config dut (.*);
    link_partner_model u_link (.i_clock(i_clock), .i_send_wake(send_wake), .i_link_up(link_up),
                               .o_wake_message(i_wake_message), .o_link_active(i_link_active));
    always #5 i_clock = ~i_clock;
    // ********************
    // Shared tasks
    // ********************
    task automatic chk(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge i_clock); #1;
        {i_cfg_valid, i_cfg_write, i_cfg_addr, i_cfg_byte_en, i_cfg_wdata} = {1'b1, wr, a, be, d};
        @(posedge i_clock); #1;
        i_cfg_valid = 0;
        rd = o_cfg_rdata;
        chk(o_cfg_done, 1, "done");
    endtask : cfg
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        cfg(0, a, 4'hF, '0);
        chk(rd, e, "read");
    endtask : rdchk
    task automatic rx(input rx_kind_t k, input logic [7:0] b, input logic w, m, input logic [31:0] a,
                      input logic [2:0] e);
        @(posedge i_clock); #1;
        i_rx_kind = k;
        {i_rx_valid, i_rx_bus, i_rx_in_window, i_bus_master_enable, i_rx_addr} = {1'b1, b, w, m, a};
        @(posedge i_clock); #1;
        i_rx_valid = 0;
        chk({o_rx_unsupported, o_rx_malformed_fatal, o_rx_ioapic_forward}, e, "rx flags");
    endtask : rx
    // ********************
    // Scenarios
    // ********************
    task automatic t_reset;
        logic [11:0] a[11] = '{12'h0A4, 12'h0D8, 12'h0DC, 12'h0E0, 12'h100, 12'h108, 12'h10C, 12'h110,
                               12'h114, 12'h0F0, 12'h100};
        logic [31:0] e[11] = '{32'h0, 32'h0811_0000, 32'h0, 32'h8007_0000, 32'h1801_0002, 32'h1, 32'h0,
                               32'h1, 32'h8000_00FF, 32'h0, 32'h1801_0002};
        chk({o_unique_clock_exit_latency, o_common_clock_exit_latency, o_class_to_channel_map, o_sub_class},
            {3'h4, 3'h2, 7'h7F, 8'h04}, "reset outputs");
        cfg(1, 12'h0F0, 4'hF, 32'hFFFF_FFFF);
        foreach (a[i]) begin
            if (i == 10) cfg(1, 12'h100, 4'hF, 32'h0);
            rdchk(a[i], e[i]);
        end
    endtask : t_reset
    task automatic t_power;
        logic [1:0] w[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
        logic [1:0] e[4] = '{2'h3, 2'h3, 2'h3, 2'h0};
        foreach (w[i]) begin
            cfg(1, 12'h0A4, 4'h1, {30'h0, w[i]});
            rdchk(12'h0A4, {30'h0, e[i]});
            chk(o_refuse_io_mem & o_refuse_type1_cfg, e[i][0], "refusal");
        end
    endtask : t_power
    task automatic t_wake;
        send_wake = 1;
        @(posedge i_clock); #1 send_wake = 0;
        repeat (2) @(posedge i_clock);
        rdchk(12'h0A4, 32'h0000_8000);
        cfg(1, 12'h0A4, 4'h2, 32'h0000_0100);
        chk(o_wake_enable_flag, 1, "wake enable");
        i_resetn = 0;
        repeat (2) @(posedge i_clock); #1 i_resetn = 1;
        rdchk(12'h0A4, 32'h0000_0100);
        i_resume_resetn = 0;
        @(posedge i_clock); #1 i_resume_resetn = 1;
        chk(o_wake_enable_flag, 0, "wake enable reset");
    endtask : t_wake
    task automatic t_events;
        cfg(1, 12'h0D8, 4'hF, 32'hC011_0003);
        {i_command_completed, i_root_wake_status, link_up} = 3'b111;
        repeat (4) @(posedge i_clock); #1;
        chk(o_link_active_changed, 1, "link change");
        chk({o_acpi_control_interrupt, o_system_mgmt_interrupt}, 2'b11, "irqs");
        rdchk(12'h0DC, 32'hC000_0019);
        cfg(1, 12'h0DC, 4'hF, 32'h0);
        rdchk(12'h0DC, 32'hC000_0019);
        cfg(1, 12'h0DC, 4'hF, 32'hFFFF_FFFF);
        rdchk(12'h0DC, 32'h0);
        chk({o_acpi_control_interrupt, o_system_mgmt_interrupt}, 2'b00, "irqs cleared");
        cfg(1, 12'h0D8, 4'hF, 32'h0011_0000);
        {i_command_completed, i_root_wake_status, i_link_active_changed_clear} = 3'b001;
        @(posedge i_clock); #1;
        {i_attention_pressed, i_presence_changed, i_root_wake_status, i_link_active_changed_clear} = 4'b1110;
        link_up = 0;
        repeat (4) @(posedge i_clock); #1;
        rdchk(12'h0DC, 32'h0);
    endtask : t_events
    task automatic t_misc;
        cfg(1, 12'h0D8, 4'hF, 32'h240A_0080);
        @(posedge i_clock); #1;
        chk(o_rx_ready, 0, "hold off");
        rx(RX_MEM_WRITE, 8'h01, 1, 1, 32'h0, 3'h0);
        rdchk(12'h0D8, 32'h2C0A_0080);
        chk({o_unique_clock_exit_latency, o_common_clock_exit_latency}, {3'h2, 3'h4}, "latency");
        i_loopback_mode = 1;
        cfg(1, 12'h0D8, 4'hF, 32'h170A_0080);
        @(posedge i_clock); #1;
        chk({o_loopback_xlation_active, o_rx_ready}, 2'b11, "loopback");
        rx(RX_MEM_WRITE, 8'h01, 1, 1, 32'h0, 3'h4);
        rx(RX_MEM_READ, 8'h06, 1, 1, 32'h0, 3'h2);
        rx(RX_OTHER, 8'h01, 0, 0, 32'h0, 3'h0);
        rx(RX_MEM_READ, 8'h03, 0, 1, 32'h0, 3'h4);
        rx(RX_MEM_WRITE, 8'h03, 1, 0, 32'h0, 3'h4);
        rx(RX_MEM_READ, 8'h03, 1, 1, 32'hFEC1_8000, 3'h1);
        rx(RX_MEM_READ, 8'h05, 1, 1, 32'hFEC1_7FFF, 3'h0);
        {i_bridge_type_select, i_lane_reversal_strap} = 2'b10;
        repeat (4) @(posedge i_clock);
        rdchk(12'h0D8, 32'h170A_0084);
        chk({o_sub_class, o_header_type_1}, 9'h000, "host bridge");
    endtask : t_misc
    task automatic t_vc;
        cfg(1, 12'h10C, 4'hF, 32'hFFFF_FFFF);
        rdchk(12'h10C, 32'h0000_000E);
        cfg(1, 12'h114, 4'hF, 32'h0);
        rdchk(12'h114, 32'h8000_0001);
        chk(o_class_to_channel_map, 7'h00, "map");
    endtask : t_vc
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (10) @(posedge i_clock);
        #1 {i_resetn, i_resume_resetn} = 2'b11;
        t_reset();
        t_power();
        t_wake();
        t_events();
        t_misc();
        t_vc();
        test_done();
    end
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
endmodule : tb_root_port_pm_event_config
